/* File: rtl/smaw_consts.vh */
// constants for the stop mode auto wakeup block
`ifndef SMAW_CONSTS_VH
`define SMAW_CONSTS_VH

// register addresses on the plain register port
`define SMAW_ADDR_PORT_A 8'h00
`define SMAW_ADDR_KBD_SC 8'h1A
`define SMAW_ADDR_KBD_IE 8'h1B
`define SMAW_ADDR_CFG_TWO 8'h1E
`define SMAW_ADDR_CFG_ONE 8'h1F
`define SMAW_ADDR_IRQ_STAT 8'h30
`define SMAW_ADDR_IRQ_MASK 8'h31

// field positions
`define SMAW_PA_WAKE_BIT 6
`define SMAW_PA_DATA_W 6
`define SMAW_SC_PEND_BIT 3
`define SMAW_SC_ACK_BIT 2
`define SMAW_SC_MASK_BIT 1
`define SMAW_SC_MODE_BIT 0
`define SMAW_IE_WAKE_BIT 6
`define SMAW_CFG1_PSEL_BIT 0
`define SMAW_CFG2_KEEP_BIT 0

// event bits of the interrupt status and mask registers
`define SMAW_EV_W 4
`define SMAW_EV_OVF 0
`define SMAW_EV_LATCH 1
`define SMAW_EV_ACK 2
`define SMAW_EV_STOP 3

// reset values
`define SMAW_RST_BYTE 8'h00
`define SMAW_RST_EV 4'h0
`define SMAW_RST_PA 6'h00

// generator periods in source cycles: 512 short, 16,384 long
`define SMAW_CNT_W 14
`define SMAW_SHORT_LAST 14'h01FF
`define SMAW_LONG_LAST 14'h3FFF
`define SMAW_CNT_ZERO 14'h0000
`define SMAW_CNT_ONE 14'h0001

`endif

/* File: rtl/smaw_counter.v */
// wakeup request generator counter
`timescale 1ns/10ps
`default_nettype none
`include "smaw_consts.vh"

module smaw_counter (
    input wire i_clk_sys,
    input wire i_sys_rst,
    input wire i_restart,
    input wire i_run,
    input wire i_tick,
    input wire i_short,
    output reg o_overflow,
    output reg [`SMAW_CNT_W-1:0] o_count
);

    wire [`SMAW_CNT_W-1:0] last_count;

    assign last_count = i_short ? `SMAW_SHORT_LAST : `SMAW_LONG_LAST;

    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_count <= `SMAW_CNT_ZERO;
            o_overflow <= 1'b0;
        end else begin
            o_overflow <= 1'b0;
            if (i_restart || !i_run) begin
                // held at zero so each stop entry starts afresh
                o_count <= `SMAW_CNT_ZERO;
            end else if (i_tick) begin
                if (o_count >= last_count) begin
                    o_count <= `SMAW_CNT_ZERO;
                    o_overflow <= 1'b1;
                end else begin
                    o_count <= o_count + `SMAW_CNT_ONE;
                end
            end
        end
    end

endmodule
`default_nettype wire

/* File: rtl/smaw_top.v */
// stop mode auto wakeup unit with its shared keyboard and config registers
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "smaw_consts.vh"

module smaw_top (
    input wire i_clk_sys,
    input wire i_sys_rst,
    input wire i_stop_mode,
    input wire i_wait_mode,
    input wire i_wake_rc_osc,
    input wire i_bus_clock_double,
    input wire i_kbd_pin_req,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    output reg o_kbd_cpu_irq,
    output reg o_stop_exit_req,
    output reg o_wake_latch,
    output reg o_wake_osc_run,
    output reg o_bus_clk_keep,
    output reg o_wdog_short_period,
    output reg [`SMAW_PA_DATA_W-1:0] o_port_a_data,
    output reg [`SMAW_PA_DATA_W-1:0] o_kbd_pin_enable,
    output reg o_irq
);

    localparam MODE_RUN = 2'b00;
    localparam MODE_WAIT = 2'b01;
    localparam MODE_STOP = 2'b10;

    reg [1:0] mode_reg;
    reg [1:0] mode_next;
    reg stop_entry_reg;

    reg rc_sync1_reg;
    reg rc_sync2_reg;
    reg rc_sync3_reg;
    reg bus_sync1_reg;
    reg bus_sync2_reg;
    reg bus_sync3_reg;

    reg [`SMAW_PA_DATA_W-1:0] port_a_data_reg;
    reg wake_latch_reg;
    reg wake_latch_next;
    reg kbd_pin_latch_reg;
    reg kbd_pin_latch_next;
    reg kbd_irq_mask_reg;
    reg kbd_mode_reg;
    reg wake_irq_enable_reg;
    reg [`SMAW_PA_DATA_W-1:0] kbd_pin_enable_reg;
    reg [7:0] config_reg_one;
    reg [7:0] config_reg_two;
    reg cfg_one_done_reg;
    reg cfg_two_done_reg;
    reg [`SMAW_EV_W-1:0] irq_stat_reg;
    reg [`SMAW_EV_W-1:0] irq_stat_next;
    reg [`SMAW_EV_W-1:0] irq_mask_reg;
    reg [7:0] rdata_next;

    wire in_stop;
    wire stop_next;
    wire rc_rise;
    wire bus_rise;
    wire osc_keep_in_stop;
    wire period_select;
    wire gen_run;
    wire gen_tick;
    wire wake_request;
    wire kbd_ack;
    wire wr_port_a;
    wire wr_kbd_sc;
    wire wr_kbd_ie;
    wire wr_cfg_one;
    wire wr_cfg_two;
    wire wr_irq_mask;
    wire rd_irq_stat;
    wire kbd_pending_flag;
    wire service_req;
    wire [`SMAW_EV_W-1:0] events;

    // power mode tracking; stop outranks wait
    always @* begin
        if (i_stop_mode) begin
            mode_next = MODE_STOP;
        end else if (i_wait_mode) begin
            mode_next = MODE_WAIT;
        end else begin
            mode_next = MODE_RUN;
        end
    end

    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            mode_reg <= MODE_RUN;
            stop_entry_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            case (mode_reg)
                MODE_RUN: begin
                    stop_entry_reg <= (mode_next == MODE_STOP);
                end
                MODE_WAIT: begin
                    stop_entry_reg <= (mode_next == MODE_STOP);
                end
                MODE_STOP: begin
                    stop_entry_reg <= 1'b0;
                end
                default: begin
                    stop_entry_reg <= 1'b0;
                end
            endcase
        end
    end

    assign in_stop = (mode_reg == MODE_STOP);
    assign stop_next = (mode_next == MODE_STOP);

    // both clock sources arrive asynchronously; edges seen after two flops
    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            rc_sync1_reg <= 1'b0;
            rc_sync2_reg <= 1'b0;
            rc_sync3_reg <= 1'b0;
            bus_sync1_reg <= 1'b0;
            bus_sync2_reg <= 1'b0;
            bus_sync3_reg <= 1'b0;
        end else begin
            rc_sync1_reg <= i_wake_rc_osc;
            rc_sync2_reg <= rc_sync1_reg;
            rc_sync3_reg <= rc_sync2_reg;
            bus_sync1_reg <= i_bus_clock_double;
            bus_sync2_reg <= bus_sync1_reg;
            bus_sync3_reg <= bus_sync2_reg;
        end
    end

    assign rc_rise = rc_sync2_reg & ~rc_sync3_reg;
    assign bus_rise = bus_sync2_reg & ~bus_sync3_reg;

    assign osc_keep_in_stop = config_reg_two[`SMAW_CFG2_KEEP_BIT];
    assign period_select = config_reg_one[`SMAW_CFG1_PSEL_BIT];

    // generator runs only in stop and only when enabled
    assign gen_run = in_stop & wake_irq_enable_reg;
    assign gen_tick = osc_keep_in_stop ? bus_rise : rc_rise;

    smaw_counter smaw_counter_i (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_restart(stop_entry_reg),
        .i_run(gen_run),
        .i_tick(gen_tick),
        .i_short(period_select),
        .o_overflow(wake_request),
        .o_count()
    );

    // register port decode
    assign wr_port_a = i_wr & (i_addr == `SMAW_ADDR_PORT_A);
    assign wr_kbd_sc = i_wr & (i_addr == `SMAW_ADDR_KBD_SC);
    assign wr_kbd_ie = i_wr & (i_addr == `SMAW_ADDR_KBD_IE);
    assign wr_cfg_one = i_wr & (i_addr == `SMAW_ADDR_CFG_ONE);
    assign wr_cfg_two = i_wr & (i_addr == `SMAW_ADDR_CFG_TWO);
    assign wr_irq_mask = i_wr & (i_addr == `SMAW_ADDR_IRQ_MASK);
    assign rd_irq_stat = i_rd & (i_addr == `SMAW_ADDR_IRQ_STAT);

    assign kbd_ack = wr_kbd_sc & i_wdata[`SMAW_SC_ACK_BIT];

    // set wins over acknowledge so a request in the clear cycle survives
    always @* begin
        wake_latch_next = wake_latch_reg;
        if (kbd_ack) begin
            wake_latch_next = 1'b0;
        end
        if (wake_request && wake_irq_enable_reg) begin
            wake_latch_next = 1'b1;
        end
        kbd_pin_latch_next = kbd_pin_latch_reg;
        if (kbd_ack) begin
            kbd_pin_latch_next = 1'b0;
        end
        if (i_kbd_pin_req) begin
            kbd_pin_latch_next = 1'b1;
        end
    end

    // config registers take one write after each reset
    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            config_reg_one <= `SMAW_RST_BYTE;
            config_reg_two <= `SMAW_RST_BYTE;
            cfg_one_done_reg <= 1'b0;
            cfg_two_done_reg <= 1'b0;
        end else begin
            if (wr_cfg_one && !cfg_one_done_reg) begin
                config_reg_one <= i_wdata;
                cfg_one_done_reg <= 1'b1;
            end
            if (wr_cfg_two && !cfg_two_done_reg) begin
                config_reg_two <= i_wdata;
                cfg_two_done_reg <= 1'b1;
            end
        end
    end

    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            port_a_data_reg <= `SMAW_RST_PA;
            wake_latch_reg <= 1'b0;
            kbd_pin_latch_reg <= 1'b0;
            kbd_irq_mask_reg <= 1'b0;
            kbd_mode_reg <= 1'b0;
            wake_irq_enable_reg <= 1'b0;
            kbd_pin_enable_reg <= `SMAW_RST_PA;
        end else begin
            wake_latch_reg <= wake_latch_next;
            kbd_pin_latch_reg <= kbd_pin_latch_next;
            if (wr_port_a) begin
                // bit 6 has no data latch; writes to it are dropped
                port_a_data_reg <= i_wdata[`SMAW_PA_DATA_W-1:0];
            end
            if (wr_kbd_sc) begin
                kbd_irq_mask_reg <= i_wdata[`SMAW_SC_MASK_BIT];
                kbd_mode_reg <= i_wdata[`SMAW_SC_MODE_BIT];
            end
            if (wr_kbd_ie) begin
                wake_irq_enable_reg <= i_wdata[`SMAW_IE_WAKE_BIT];
                kbd_pin_enable_reg <= i_wdata[`SMAW_PA_DATA_W-1:0];
            end
        end
    end

    // wakeup shares the keyboard flag, mask and vector
    assign kbd_pending_flag = wake_latch_reg | kbd_pin_latch_reg;
    assign service_req = ((wake_latch_reg & wake_irq_enable_reg)
        | kbd_pin_latch_reg) & ~kbd_irq_mask_reg;

    // local event status: read of the status register clears it
    assign events = {stop_entry_reg, kbd_ack,
        wake_request & wake_irq_enable_reg, wake_request};

    always @* begin
        irq_stat_next = irq_stat_reg;
        if (rd_irq_stat) begin
            irq_stat_next = `SMAW_RST_EV;
        end
        irq_stat_next = irq_stat_next | events;
    end

    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            irq_stat_reg <= `SMAW_RST_EV;
            irq_mask_reg <= `SMAW_RST_EV;
        end else begin
            irq_stat_reg <= irq_stat_next;
            if (wr_irq_mask) begin
                irq_mask_reg <= i_wdata[`SMAW_EV_W-1:0];
            end
        end
    end

    // read mux; data valid only in the cycle after the strobe
    always @* begin
        rdata_next = `SMAW_RST_BYTE;
        case (i_addr)
            `SMAW_ADDR_PORT_A: begin
                rdata_next[`SMAW_PA_DATA_W-1:0] = port_a_data_reg;
                rdata_next[`SMAW_PA_WAKE_BIT] = wake_latch_reg;
            end
            `SMAW_ADDR_KBD_SC: begin
                rdata_next[`SMAW_SC_PEND_BIT] = kbd_pending_flag;
                rdata_next[`SMAW_SC_MASK_BIT] = kbd_irq_mask_reg;
                rdata_next[`SMAW_SC_MODE_BIT] = kbd_mode_reg;
                // acknowledge bit left at zero
            end
            `SMAW_ADDR_KBD_IE: begin
                rdata_next[`SMAW_IE_WAKE_BIT] = wake_irq_enable_reg;
                rdata_next[`SMAW_PA_DATA_W-1:0] = kbd_pin_enable_reg;
            end
            `SMAW_ADDR_CFG_ONE: begin
                rdata_next = config_reg_one;
            end
            `SMAW_ADDR_CFG_TWO: begin
                rdata_next = config_reg_two;
            end
            `SMAW_ADDR_IRQ_STAT: begin
                rdata_next[`SMAW_EV_W-1:0] = irq_stat_reg;
            end
            `SMAW_ADDR_IRQ_MASK: begin
                rdata_next[`SMAW_EV_W-1:0] = irq_mask_reg;
            end
            default: begin
                rdata_next = `SMAW_RST_BYTE;
            end
        endcase
    end

    // every output registered
    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_rdata <= `SMAW_RST_BYTE;
            o_kbd_cpu_irq <= 1'b0;
            o_stop_exit_req <= 1'b0;
            o_wake_latch <= 1'b0;
            o_wake_osc_run <= 1'b0;
            o_bus_clk_keep <= 1'b0;
            o_wdog_short_period <= 1'b0;
            o_port_a_data <= `SMAW_RST_PA;
            o_kbd_pin_enable <= `SMAW_RST_PA;
            o_irq <= 1'b0;
        end else begin
            o_rdata <= i_rd ? rdata_next : `SMAW_RST_BYTE;
            o_kbd_cpu_irq <= service_req;
            o_stop_exit_req <= service_req & in_stop;
            o_wake_latch <= wake_latch_reg;
            // rc oscillator stopped outside stop to save power
            o_wake_osc_run <= stop_next & wake_irq_enable_reg
                & ~osc_keep_in_stop;
            o_bus_clk_keep <= stop_next & osc_keep_in_stop;
            // watchdog owns the bit whenever the part is out of stop
            o_wdog_short_period <= period_select & ~stop_next;
            o_port_a_data <= port_a_data_reg;
            o_kbd_pin_enable <= kbd_pin_enable_reg;
            o_irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

endmodule
`default_nettype wire

/* File: testbench/smaw_monitor.sv */
// port checker for the stop mode auto wakeup unit
`timescale 1ns/10ps
`default_nettype none
module smaw_monitor (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_stop_mode,
    input wire logic i_wait_mode,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic o_kbd_cpu_irq,
    input wire logic o_stop_exit_req,
    input wire logic o_wake_latch,
    input wire logic o_wake_osc_run,
    input wire logic o_bus_clk_keep,
    input wire logic o_wdog_short_period
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    property p_pa_top;
        i_rd && i_addr == 8'h00 |=> o_rdata[7] == 1'h0;
    endproperty
    a_pa_top: assert property (p_pa_top)
        else $error("port a top bit set");
    property p_ack_zero;
        i_rd && i_addr == 8'h1A |=> o_rdata[2] == 1'h0 && o_rdata[7:4] == 4'h0;
    endproperty
    a_ack_zero: assert property (p_ack_zero)
        else $error("ack bit read 1");
    property p_run_idle;
        (!i_stop_mode)[*3] |-> !o_wake_osc_run && !o_bus_clk_keep;
    endproperty
    a_run_idle: assert property (p_run_idle)
        else $error("source on in run");
    property p_wait_idle;
        (i_wait_mode && !i_stop_mode)[*3]
            |-> !o_wake_osc_run && !o_stop_exit_req;
    endproperty
    a_wait_idle: assert property (p_wait_idle)
        else $error("active in wait");
    property p_wdog_stop;
        i_stop_mode[*3] |-> !o_wdog_short_period;
    endproperty
    a_wdog_stop: assert property (p_wdog_stop)
        else $error("watchdog in stop");
    // exit request must follow stop two cycles back, not just mirror the irq
    property p_exit_irq;
        o_stop_exit_req |-> o_kbd_cpu_irq && $past(i_stop_mode, 2);
    endproperty
    a_exit_irq: assert property (p_exit_irq)
        else $error("exit without irq");
    property p_mask_blk;
        i_wr && i_addr == 8'h1A && i_wdata[1] |-> ##2 !o_kbd_cpu_irq;
    endproperty
    a_mask_blk: assert property (p_mask_blk)
        else $error("mask ignored");
    property p_ack_clr;
        (!i_stop_mode)[*8] ##0 (i_wr && i_addr == 8'h1A && i_wdata[2])
            |-> ##2 !o_wake_latch;
    endproperty
    a_ack_clr: assert property (p_ack_clr)
        else $error("ack kept latch");
    property p_no_set_run;
        (!i_stop_mode)[*8] |-> !$rose(o_wake_latch);
    endproperty
    a_no_set_run: assert property (p_no_set_run)
        else $error("latch set in run");
endmodule
bind smaw_top smaw_monitor smaw_monitor_i (.i_clk_sys, .i_sys_rst,
    .i_stop_mode, .i_wait_mode, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .o_kbd_cpu_irq, .o_stop_exit_req, .o_wake_latch, .o_wake_osc_run,
    .o_bus_clk_keep, .o_wdog_short_period);
`default_nettype wire

/* File: testbench/smaw_far_model.sv */
// wakeup clock sources, running only while the unit asks for them
`timescale 1ns/10ps
`default_nettype none
module smaw_far_model (
    input wire logic i_clk_sys,
    input wire logic i_run_rc,
    input wire logic i_run_bus,
    input wire logic [3:0] i_half,
    output logic o_wake_rc_osc,
    output logic o_bus_clock_double,
    output logic [15:0] o_edges
);
    logic [3:0] ph = 4'h0;
    logic src = 1'h0;
    initial o_edges = 16'h0000;
    // sources stand still low outside stop, as the real oscillators do
    assign o_wake_rc_osc = src & i_run_rc;
    assign o_bus_clock_double = src & i_run_bus;
    always @(posedge i_clk_sys) begin
        if (!(i_run_rc | i_run_bus)) begin
            ph <= 4'h0;
            src <= 1'h0;
            o_edges <= 16'h0000;
        end else if (ph == i_half - 4'h1) begin
            ph <= 4'h0;
            src <= ~src;
            if (!src) begin
                o_edges <= o_edges + 16'h0001;
            end
        end else begin
            ph <= ph + 4'h1;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/smaw_top_tb_top.sv */
// self-checking bench for the stop mode auto wakeup unit
`timescale 1ns/10ps
`default_nettype none
module smaw_top_tb_top;
    logic i_clk_sys = 1'h0;
    logic i_sys_rst = 1'h1;
    logic i_stop_mode = 1'h0;
    logic i_wait_mode = 1'h0;
    logic i_kbd_pin_req = 1'h0;
    logic i_wr = 1'h0;
    logic i_rd = 1'h0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic [3:0] half = 4'h4;
    logic [31:0] seed = 32'h38D3;
    logic [7:0] ra [8] = '{8'h00, 8'h1A, 8'h1B, 8'h1E, 8'h1F, 8'h30, 8'h31,
        8'h55};
    int err_count = 0;
    int checked = 0;
    wire i_wake_rc_osc, i_bus_clock_double, o_kbd_cpu_irq, o_stop_exit_req;
    wire o_wake_latch, o_wake_osc_run, o_bus_clk_keep, o_wdog_short_period;
    wire o_irq;
    wire [5:0] o_port_a_data, o_kbd_pin_enable;
    wire [7:0] o_rdata;
    wire [15:0] edges;
    always #50 i_clk_sys = ~i_clk_sys;
    smaw_top smaw_top_i (.i_clk_sys, .i_sys_rst, .i_stop_mode, .i_wait_mode,
        .i_wake_rc_osc, .i_bus_clock_double, .i_kbd_pin_req, .i_addr,
        .i_wdata, .i_wr, .i_rd, .o_rdata, .o_kbd_cpu_irq, .o_stop_exit_req,
        .o_wake_latch, .o_wake_osc_run, .o_bus_clk_keep, .o_wdog_short_period,
        .o_port_a_data, .o_kbd_pin_enable, .o_irq);
    smaw_far_model smaw_far_model_i (.i_clk_sys, .i_run_rc(o_wake_osc_run),
        .i_run_bus(o_bus_clk_keep), .i_half(half),
        .o_wake_rc_osc(i_wake_rc_osc), .o_bus_clock_double(i_bus_clock_double),
        .o_edges(edges));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {1'h0, x[31:1]} ^ (x[0] ? 32'hA3000000 : 32'h00000000);
    endfunction
    task automatic chk(input string n, input logic [7:0] s,
        input logic [7:0] e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic b(input string n, input logic s, input logic e);
        chk(n, {7'h00, s}, {7'h00, e});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_wr <= 1'h1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk_sys);
        i_rd <= 1'h1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'h0;
        @(negedge i_clk_sys);
        chk("rdata", o_rdata, e);
    endtask
    task automatic pause();
        repeat (4) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
    endtask
    // the model counts source edges; margin covers the two-flop sync
    task automatic wait_ed(input logic [15:0] n, input int extra);
        while (edges < n) @(posedge i_clk_sys);
        repeat (extra) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
    endtask
    task automatic do_reset();
        @(posedge i_clk_sys) i_sys_rst <= 1'h1;
        repeat (7) @(posedge i_clk_sys);
        i_sys_rst <= 1'h0;
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge i_clk_sys);
        err_count++;
        end_sim();
    end
    initial begin
        do_reset();
        foreach (ra[k]) rd(ra[k], 8'h00);
        repeat (4) begin
            seed = lfsr(seed);
            wr(8'h00, seed[7:0]);
            wr(8'h1B, {2'h0, seed[13:8]});
            rd(8'h00, {2'h0, seed[5:0]});
            chk("pa out", {2'h0, o_port_a_data}, {2'h0, seed[5:0]});
            rd(8'h1B, {2'h0, seed[13:8]});
            chk("pin en", {2'h0, o_kbd_pin_enable}, {2'h0, seed[13:8]});
        end
        @(posedge i_clk_sys) i_kbd_pin_req <= 1'h1;
        @(posedge i_clk_sys) i_kbd_pin_req <= 1'h0;
        pause();
        rd(8'h1A, 8'h08);
        wr(8'h31, 8'h0B);
        wr(8'h1A, 8'h04);
        pause();
        b("irq", o_irq, 1'h0);
        rd(8'h1A, 8'h00);
        wr(8'h1A, 8'h03);
        rd(8'h1A, 8'h03);
        wr(8'h31, 8'h0F);
        pause();
        b("irq", o_irq, 1'h1);
        rd(8'h30, 8'h04);
        wr(8'h1B, 8'h40);
        wr(8'h1F, 8'h01);
        wr(8'h1E, 8'h00);
        wr(8'h1F, 8'h00);
        rd(8'h1F, 8'h01);
        wr(8'h1A, 8'h00);
        @(posedge i_clk_sys) i_stop_mode <= 1'h1;
        wait_ed(16'd511, 6);
        b("latch", o_wake_latch, 1'h0);
        b("wdog", o_wdog_short_period, 1'h0);
        wait_ed(16'd512, 6);
        b("latch", o_wake_latch, 1'h1);
        b("exit", o_stop_exit_req, 1'h1);
        rd(8'h00, {2'h1, seed[5:0]});
        rd(8'h30, 8'h0B);
        wr(8'h1A, 8'h04);
        pause();
        b("latch", o_wake_latch, 1'h0);
        wait_ed(16'd1024, 6);
        b("latch", o_wake_latch, 1'h1);
        wr(8'h1A, 8'h02);
        pause();
        b("cpu irq", o_kbd_cpu_irq, 1'h0);
        wr(8'h1A, 8'h00);
        pause();
        b("cpu irq", o_kbd_cpu_irq, 1'h1);
        @(posedge i_clk_sys) i_stop_mode <= 1'h0;
        wr(8'h1B, 8'h00);
        pause();
        b("cpu irq", o_kbd_cpu_irq, 1'h0);
        b("wdog", o_wdog_short_period, 1'h1);
        rd(8'h00, {2'h1, seed[5:0]});
        @(posedge i_clk_sys) i_wait_mode <= 1'h1;
        wr(8'h1B, 8'h40);
        pause();
        b("osc", o_wake_osc_run, 1'h0);
        wr(8'h1A, 8'h04);
        pause();
        b("latch", o_wake_latch, 1'h0);
        @(posedge i_clk_sys) i_wait_mode <= 1'h0;
        i_stop_mode <= 1'h1;
        wait_ed(16'd300, 0);
        @(posedge i_clk_sys) i_stop_mode <= 1'h0;
        pause();
        @(posedge i_clk_sys) i_stop_mode <= 1'h1;
        wait_ed(16'd511, 6);
        b("latch", o_wake_latch, 1'h0);
        wait_ed(16'd512, 6);
        b("latch", o_wake_latch, 1'h1);
        @(posedge i_clk_sys) i_stop_mode <= 1'h0;
        do_reset();
        pause();
        b("latch", o_wake_latch, 1'h0);
        half <= 4'h2;
        wr(8'h1B, 8'h40);
        wr(8'h1F, 8'h00);
        wr(8'h1E, 8'h01);
        @(posedge i_clk_sys) i_stop_mode <= 1'h1;
        pause();
        b("keep", o_bus_clk_keep, 1'h1);
        b("osc", o_wake_osc_run, 1'h0);
        wait_ed(16'd16383, 0);
        b("latch", o_wake_latch, 1'h0);
        wait_ed(16'd16384, 6);
        b("latch", o_wake_latch, 1'h1);
        end_sim();
    end
endmodule
`default_nettype wire
